// File: common/cso_regs.svh
// Timing figures, character codes and message layout constants for the credential output
`ifndef CSO_REGS_SVH
`define CSO_REGS_SVH

// Core clock period
`define CSO_CLK_NS            4
// Clocked formats: bit clock period, data lead before falling clock, clock low time
`define CSO_BIT_PERIOD_NS     320000
`define CSO_DATA_LEAD_NS      100000
`define CSO_CLOCK_LOW_NS      100000
// Card-present strobe lead and trail around the data bits
`define CSO_STROBE_LEAD_NS    12000000
`define CSO_STROBE_TRAIL_NS   12000000
// Pulse format: pulse width and bit-to-bit period
`define CSO_PULSE_WIDTH_NS    100000
`define CSO_PULSE_PERIOD_NS   1000000

// Character codes
`define CSO_START_CHAR        4'hb
`define CSO_END_CHAR          4'hf
`define CSO_SEP_FIRST         4'h0
`define CSO_SEP_SECOND        4'h1
`define CSO_EXT_CONST         32'h1a210001

// Message layout
`define CSO_CHAR_BITS         6'h05
`define CSO_PULSE_BITS        6'h21
`define CSO_ZERO_SHORT        6'h0a
`define CSO_ZERO_EXT          6'h0f
`define CSO_CHARS_PLAIN       5'h0c
`define CSO_CHARS_ZERO        5'h0d
`define CSO_CHARS_EXT         5'h17

`endif

// File: common/cso_pkg.sv
// Types shared by the credential output block
package cso_pkg;

  // Output format selection
  typedef enum logic [1:0] {
    FMT_PULSE33 = 2'h0,
    FMT_PLAIN   = 2'h1,
    FMT_ZERO    = 2'h3,
    FMT_EXT     = 2'h2
  } fmt_t;

  // Transmit sequencer states, Gray coded along the message path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEAD  = 3'h1,
    ST_PRE   = 3'h3,
    ST_CHAR  = 3'h2,
    ST_POST  = 3'h6,
    ST_TRAIL = 3'h7
  } state_t;

endpackage : cso_pkg

// File: common/cso_fifo_if.sv
// Valid/ready credential queue carrier between the transmitter and its FIFO
`timescale 1ns/1ps
`default_nettype none

interface cso_fifo_if #(parameter int W = 64);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (input in_valid, output in_ready, input in_data,
                output out_valid, input out_ready, output out_data);
  modport user (output in_valid, input in_ready, output in_data,
                input out_valid, output out_ready, input out_data);
endinterface : cso_fifo_if

`default_nettype wire

// File: hw/cso_fifo.sv
// Credential FIFO with registered head word and honest full/empty
`timescale 1ns/1ps
`default_nettype none

module cso_fifo
  #(parameter int W = 64,
    parameter int D = 8)
  (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Queue ports
  cso_fifo_if.fifo  q
  );

  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic [W-1:0]  head, next_head;
  logic          push, pop;

  // Handshakes; full refuses the writer until the reader drains
  assign q.in_ready  = (count != CW'(D));
  assign q.out_valid = (count != '0);
  assign q.out_data  = head;
  assign push        = q.in_valid & q.in_ready;
  assign pop         = q.out_valid & q.out_ready;

  // Pointer and head update; bypass covers a write into an empty head slot
  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = CW'(count + CW'(push) - CW'(pop));
    next_head   = (push && (wr_ptr == next_rd_ptr)) ? q.in_data : mem[next_rd_ptr];
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      head   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      head   <= next_head;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= q.in_data;
    end
  end

endmodule : cso_fifo

`default_nettype wire

// File: hw/credential_serial_output.sv
// Credential serial transmitter: 33-bit pulse format and clocked BCD formats
// Function
// - Pulse mode sends 16-bit facility code in bits 1-16, MSB first.
// - Pulse mode sends 16-bit user ID in bits 17-32, MSB first.
// - Pulse mode bit 33 is odd parity over bits 1-32.
// - Clocked lines are active low: pulled low to assert, released otherwise.
// - Bit clock period 290-350 us, nominally 320 us.
// - Strobe asserted 8-20 ms, nominally 12, before first data bit.
// - Strobe released 8-20 ms, nominally 12, after last data bit.
// - Each character occupies exactly five bit clock periods.
// - Character: BCD digit LSB first in bits 1-4, bit 5 odd parity.
// - Every clocked message begins with start character hex B.
// - End character hex F follows the last ID digit.
// - Plain format: start, five facility, five user digits, end; no parity char.
// - Zero-preamble format: ten zero bits, plain layout, then parity character.
// - Parity character covers start through end, sent right after end.
// - Parity character is XOR of all 4-bit values start through end.
// - Extended format: 15 zeros, S, constant, 4 fac, 0, 1, 6 user, E, L, 15 zeros.
// - Pulse format: zero bit pulses zero line, one bit pulses one line.
// - Pulse width 100 us, bits start 1000 us apart.
`timescale 1ns/1ps
`default_nettype none
`include "cso_regs.svh"

module credential_serial_output
  import cso_pkg::*;
  #(parameter int unsigned BIT_CYCLES    = `CSO_BIT_PERIOD_NS / `CSO_CLK_NS,
    parameter int unsigned LEAD_CYCLES   = `CSO_DATA_LEAD_NS / `CSO_CLK_NS,
    parameter int unsigned LOW_CYCLES    = `CSO_CLOCK_LOW_NS / `CSO_CLK_NS,
    parameter int unsigned STROBE_LEAD   = `CSO_STROBE_LEAD_NS / `CSO_CLK_NS,
    parameter int unsigned STROBE_TRAIL  = `CSO_STROBE_TRAIL_NS / `CSO_CLK_NS,
    parameter int unsigned PULSE_CYCLES  = `CSO_PULSE_WIDTH_NS / `CSO_CLK_NS,
    parameter int unsigned PERIOD_CYCLES = `CSO_PULSE_PERIOD_NS / `CSO_CLK_NS,
    parameter int          FIFO_DEPTH    = 8)
  (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Configuration held by the surrounding logic
  input  wire logic [1:0]  format_sel,
  input  wire logic        strobe_enable,
  // Credential request: facility and user (binary in pulse mode, BCD otherwise)
  input  wire logic        cred_valid,
  output logic             cred_ready,
  input  wire logic [31:0] cred_facility,
  input  wire logic [31:0] cred_user,
  // Open-drain data line (zero line in pulse mode)
  output logic             data_line_out,
  output logic             data_line_oe_n,
  // Open-drain clock line (one line in pulse mode)
  output logic             clock_line_out,
  output logic             clock_line_oe_n,
  // Open-drain card-present strobe
  output logic             card_present_strobe_out,
  output logic             card_present_strobe_oe_n,
  // Status
  output logic             busy
  );

  localparam int TW = 22;

  // Nibble k of a word, counted from the least significant digit
  function automatic logic [3:0] nib(input logic [31:0] w, input int k);
    nib = w[4*k +: 4];
  endfunction : nib

  // Character value at position idx of a clocked message
  function automatic logic [3:0] char_at(input fmt_t f, input logic [4:0] idx,
                                         input logic [31:0] fac, input logic [31:0] uid);
    int i;
    i = int'(idx);
    if (i == 0) char_at = `CSO_START_CHAR;
    else if (f == FMT_EXT) begin
      if (i <= 8) char_at = nib(`CSO_EXT_CONST, 8 - i);
      else if (i <= 12) char_at = nib(fac, 12 - i);
      else if (i == 13) char_at = `CSO_SEP_FIRST;
      else if (i == 14) char_at = `CSO_SEP_SECOND;
      else if (i <= 20) char_at = nib(uid, 20 - i);
      else char_at = `CSO_END_CHAR;
    end else begin
      if (i <= 5) char_at = nib(fac, 5 - i);
      else if (i <= 10) char_at = nib(uid, 10 - i);
      else char_at = `CSO_END_CHAR;
    end
  endfunction : char_at

  // Characters per message, parity character included
  function automatic logic [4:0] char_count(input fmt_t f);
    case (f)
      FMT_PLAIN: char_count = `CSO_CHARS_PLAIN;
      FMT_ZERO:  char_count = `CSO_CHARS_ZERO;
      default:   char_count = `CSO_CHARS_EXT;
    endcase
  endfunction : char_count

  // Zero bits before (and, for the extended format, after) the characters
  function automatic logic [5:0] zero_count(input fmt_t f);
    case (f)
      FMT_ZERO: zero_count = `CSO_ZERO_SHORT;
      FMT_EXT:  zero_count = `CSO_ZERO_EXT;
      default:  zero_count = 6'h00;
    endcase
  endfunction : zero_count

  state_t       state, next_state;
  fmt_t         fmt, next_fmt;
  logic         use_strobe, next_use_strobe;
  logic [TW-1:0] tcnt, next_tcnt;
  logic [5:0]   bcnt, next_bcnt;
  logic [4:0]   cidx, next_cidx;
  logic [3:0]   lrc, next_lrc;
  logic [31:0]  fac, next_fac;
  logic [31:0]  uid, next_uid;
  logic [32:0]  shreg, next_shreg;
  logic         pulse_mode, has_lrc, slot_end, in_slot, bit_now;
  logic [3:0]   cur_char;
  logic [63:0]  head;
  logic         head_valid, pop;
  logic         next_data_oe_n, next_clock_oe_n, next_strobe_oe_n;

  // Credential queue; its ready is the request port's ready
  cso_fifo_if #(.W(64)) q ();
  cso_fifo #(.W(64), .D(FIFO_DEPTH)) u_fifo (
    .clk    (clk),
    .resetn (resetn),
    .q      (q.fifo)
  );
  assign q.in_valid  = cred_valid;
  assign q.in_data   = {cred_facility, cred_user};
  assign cred_ready  = q.in_ready;
  assign head        = q.out_data;
  assign head_valid  = q.out_valid;
  assign q.out_ready = (state == ST_IDLE);
  assign pop         = head_valid & q.out_ready;

  // Open drain: the pin level is only ever pulled low
  assign data_line_out           = 1'b0;
  assign clock_line_out          = 1'b0;
  assign card_present_strobe_out = 1'b0;
  assign busy                    = (state != ST_IDLE);

  // Current bit and character decode
  always_comb begin
    pulse_mode = (fmt == FMT_PULSE33);
    has_lrc    = (fmt != FMT_PLAIN);
    in_slot    = (state == ST_PRE) || (state == ST_CHAR) || (state == ST_POST);
    slot_end   = pulse_mode ? (tcnt == TW'(PERIOD_CYCLES - 1))
                            : (tcnt == TW'(BIT_CYCLES - 1));
    cur_char   = (has_lrc && (cidx == 5'(char_count(fmt) - 5'h01))) ? lrc
                 : char_at(fmt, cidx, fac, uid);
    if (state != ST_CHAR) bit_now = 1'b0;
    else if (pulse_mode) bit_now = shreg[32];
    else if (bcnt == 6'(`CSO_CHAR_BITS - 6'h01)) bit_now = ~^cur_char;
    else bit_now = cur_char[bcnt[1:0]];
  end

  // Sequencer next state
  always_comb begin
    next_state      = state;
    next_fmt        = fmt;
    next_use_strobe = use_strobe;
    next_tcnt       = TW'(tcnt + 1'b1);
    next_bcnt       = bcnt;
    next_cidx       = cidx;
    next_lrc        = lrc;
    next_fac        = fac;
    next_uid        = uid;
    next_shreg      = shreg;
    unique case (state)
      ST_IDLE: begin
        next_tcnt = '0;
        if (pop) begin
          next_fmt        = fmt_t'(format_sel);
          next_use_strobe = strobe_enable;
          next_fac        = head[63:32];
          next_uid        = head[31:0];
          next_shreg      = {head[47:32], head[15:0], ~^{head[47:32], head[15:0]}};
          next_bcnt       = '0;
          next_cidx       = '0;
          next_lrc        = '0;
          if (strobe_enable) next_state = ST_LEAD;
          else if (zero_count(fmt_t'(format_sel)) != 6'h00) next_state = ST_PRE;
          else next_state = ST_CHAR;
        end
      end
      ST_LEAD: begin
        if (tcnt == TW'(STROBE_LEAD - 1)) begin
          next_tcnt  = '0;
          next_state = (zero_count(fmt) != 6'h00) ? ST_PRE : ST_CHAR;
        end
      end
      ST_PRE: begin
        if (slot_end) begin
          next_tcnt = '0;
          next_bcnt = 6'(bcnt + 6'h01);
          if (bcnt == 6'(zero_count(fmt) - 6'h01)) begin
            next_bcnt  = '0;
            next_state = ST_CHAR;
          end
        end
      end
      ST_CHAR: begin
        if (slot_end) begin
          next_tcnt = '0;
          next_bcnt = 6'(bcnt + 6'h01);
          if (pulse_mode) begin
            next_shreg = {shreg[31:0], 1'b0};
            if (bcnt == 6'(`CSO_PULSE_BITS - 6'h01)) begin
              next_state = use_strobe ? ST_TRAIL : ST_IDLE;
            end
          end else if (bcnt == 6'(`CSO_CHAR_BITS - 6'h01)) begin
            next_bcnt = '0;
            next_lrc  = lrc ^ cur_char;
            next_cidx = 5'(cidx + 5'h01);
            if (cidx == 5'(char_count(fmt) - 5'h01)) begin
              next_cidx = cidx;
              if (fmt == FMT_EXT) next_state = ST_POST;
              else next_state = use_strobe ? ST_TRAIL : ST_IDLE;
            end
          end
        end
      end
      ST_POST: begin
        if (slot_end) begin
          next_tcnt = '0;
          next_bcnt = 6'(bcnt + 6'h01);
          if (bcnt == 6'(zero_count(fmt) - 6'h01)) begin
            next_state = use_strobe ? ST_TRAIL : ST_IDLE;
          end
        end
      end
      ST_TRAIL: begin
        if (tcnt == TW'(STROBE_TRAIL - 1)) begin
          next_tcnt  = '0;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Line drive; all three lines lag the sequencer by the same one cycle
  always_comb begin
    next_strobe_oe_n = !(use_strobe && (state != ST_IDLE));
    if (in_slot && pulse_mode) begin
      next_data_oe_n  = !(!bit_now && (tcnt < TW'(PULSE_CYCLES)));
      next_clock_oe_n = !(bit_now && (tcnt < TW'(PULSE_CYCLES)));
    end else if (in_slot) begin
      next_data_oe_n  = !bit_now;
      next_clock_oe_n = !((tcnt >= TW'(LEAD_CYCLES)) && (tcnt < TW'(LEAD_CYCLES + LOW_CYCLES)));
    end else begin
      next_data_oe_n  = 1'b1;
      next_clock_oe_n = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state                    <= ST_IDLE;
      fmt                      <= FMT_PULSE33;
      use_strobe               <= 1'b0;
      tcnt                     <= '0;
      bcnt                     <= '0;
      cidx                     <= '0;
      lrc                      <= '0;
      fac                      <= '0;
      uid                      <= '0;
      shreg                    <= '0;
      data_line_oe_n           <= 1'b1;
      clock_line_oe_n          <= 1'b1;
      card_present_strobe_oe_n <= 1'b1;
    end else begin
      state                    <= next_state;
      fmt                      <= next_fmt;
      use_strobe               <= next_use_strobe;
      tcnt                     <= next_tcnt;
      bcnt                     <= next_bcnt;
      cidx                     <= next_cidx;
      lrc                      <= next_lrc;
      fac                      <= next_fac;
      uid                      <= next_uid;
      shreg                    <= next_shreg;
      data_line_oe_n           <= next_data_oe_n;
      clock_line_oe_n          <= next_clock_oe_n;
      card_present_strobe_oe_n <= next_strobe_oe_n;
    end
  end

  // Helper: length of each clock-line low phase
  logic [TW-1:0] low_len;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_len <= '0;
    else if (!clock_line_oe_n) low_len <= TW'(low_len + 1'b1);
    else low_len <= '0;
  end

  property p_clock_low;
    @(posedge clk) disable iff (!resetn)
      ($rose(clock_line_oe_n) && !pulse_mode) |-> (low_len == TW'(LOW_CYCLES));
  endproperty
  a_clock_low: assert property (p_clock_low) else $error("clock low time wrong");

  property p_idle_clock;
    @(posedge clk) disable iff (!resetn)
      (state == ST_IDLE && $past(state) == ST_IDLE) |-> clock_line_oe_n && data_line_oe_n;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("line driven while idle");

  property p_start_char;
    @(posedge clk) disable iff (!resetn)
      (state == ST_CHAR && $past(state) != ST_CHAR && !pulse_mode)
        |-> (cur_char == `CSO_START_CHAR);
  endproperty
  a_start_char: assert property (p_start_char) else $error("message not opened by start");

  property p_end_char;
    @(posedge clk) disable iff (!resetn)
      (state == ST_CHAR && !pulse_mode && has_lrc && cidx == 5'(char_count(fmt) - 5'h02))
        |-> (cur_char == `CSO_END_CHAR);
  endproperty
  a_end_char: assert property (p_end_char) else $error("end character missing");

  property p_char_parity;
    @(posedge clk) disable iff (!resetn)
      (state == ST_CHAR && !pulse_mode && bcnt == 6'h04) |-> (^{cur_char, bit_now});
  endproperty
  a_char_parity: assert property (p_char_parity) else $error("character parity even");

  property p_five_bits;
    @(posedge clk) disable iff (!resetn)
      (state == ST_CHAR && !pulse_mode) |-> (bcnt < `CSO_CHAR_BITS);
  endproperty
  a_five_bits: assert property (p_five_bits) else $error("character longer than five bits");

  property p_pulse_parity;
    @(posedge clk) disable iff (!resetn)
      (state == ST_CHAR && pulse_mode && bcnt == 6'h20)
        |-> (bit_now == ~^{fac[15:0], uid[15:0]});
  endproperty
  a_pulse_parity: assert property (p_pulse_parity) else $error("frame parity wrong");

  property p_strobe_lead;
    @(posedge clk) disable iff (!resetn)
      ($past(state) == ST_LEAD && state != ST_LEAD) |-> ($past(tcnt) == TW'(STROBE_LEAD - 1));
  endproperty
  a_strobe_lead: assert property (p_strobe_lead) else $error("strobe lead time wrong");

  property p_strobe_held;
    @(posedge clk) disable iff (!resetn)
      (in_slot && use_strobe) |=> !card_present_strobe_oe_n;
  endproperty
  a_strobe_held: assert property (p_strobe_held) else $error("strobe dropped in message");

  property p_single_pop;
    @(posedge clk) disable iff (!resetn)
      pop |=> (state != ST_IDLE) && !q.out_ready;
  endproperty
  a_single_pop: assert property (p_single_pop) else $error("credential popped twice");

endmodule : credential_serial_output

`default_nettype wire

// File: verification/cso_rx_model.sv
// Receiver model of the attendance controller on the far side of the link
`timescale 1ns/1ps
`default_nettype none

module cso_rx_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Format kind and wire levels after the pull-ups
  input  wire logic        pulse_mode,
  input  wire logic        data_wire,
  input  wire logic        clock_wire,
  input  wire logic        strobe_wire,
  // Measured link timing in core cycles
  output var  logic [15:0] low_width,
  output var  logic [15:0] period,
  output var  logic [15:0] strobe_lead,
  output var  logic [15:0] strobe_trail
  );
  // Received bits, oldest first; the bench reads and clears them
  logic        bits [$];
  logic        data_q;
  logic        clock_q;
  logic        strobe_q;
  logic        first;
  logic [15:0] since_fall;
  logic [15:0] since_strobe;

  // Edge finder on the wires; the core clock oversamples the link many times
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_q       <= 1'b1;
      clock_q      <= 1'b1;
      strobe_q     <= 1'b1;
      strobe_trail <= 16'h0;
      first        <= 1'b1;
      since_fall   <= 16'h0;
      since_strobe <= 16'h0;
      low_width    <= 16'h0;
      period       <= 16'h0;
      strobe_lead  <= 16'h0;
    end else begin
      data_q       <= data_wire;
      clock_q      <= clock_wire;
      strobe_q     <= strobe_wire;
      since_fall   <= since_fall + 16'h1;
      // trail from last falling clock to strobe release
      if (!strobe_q && strobe_wire) strobe_trail <= since_fall;
      since_strobe <= strobe_wire ? 16'h0 : since_strobe + 16'h1;
      if (!pulse_mode && clock_q && !clock_wire) begin
        bits.push_back(!data_wire);
        period     <= since_fall;
        since_fall <= 16'h1;
        first      <= 1'b0;
        if (first) strobe_lead <= since_strobe;
      end
      if (!pulse_mode && !clock_q && clock_wire) low_width <= since_fall;
      if (pulse_mode && data_q && !data_wire) bits.push_back(1'b0);
      if (pulse_mode && clock_q && !clock_wire) bits.push_back(1'b1);
      // Re-arm the lead measure only while the strobe is released
      if (strobe_wire) first <= 1'b1;
    end
  end
endmodule : cso_rx_model

`default_nettype wire

// File: verification/tb_credential_serial_output.sv
// Self-checking bench for the credential serial transmitter
`timescale 1ns/1ps
`default_nettype none

module tb_credential_serial_output import cso_pkg::*;;
  logic        clk, resetn, strobe_enable, cred_valid, cred_ready, busy;
  logic [1:0]  format_sel;
  logic [31:0] cred_facility, cred_user;
  logic        d_out, d_oe_n, c_out, c_oe_n, s_out, s_oe_n;
  logic [15:0] low_width, period, strobe_lead, strobe_trail;
  logic        data_wire, clock_wire, strobe_wire, pulse_sel;
  logic        exp_bits [$];
  logic [3:0]  lrc;
  int          fails = 0;
  int          samples_checked = 0;

  // Shortened counts so a run stays small; the queue keeps its default depth
  localparam int unsigned T_BIT    = 80;
  localparam int unsigned T_LEAD   = 20;
  localparam int unsigned T_LOW    = 20;
  localparam int unsigned T_STROBE = 50;
  localparam int unsigned T_PULSE  = 10;
  localparam int unsigned T_PERIOD = 60;
  credential_serial_output #(.BIT_CYCLES(T_BIT), .LEAD_CYCLES(T_LEAD), .LOW_CYCLES(T_LOW),
    .STROBE_LEAD(T_STROBE), .STROBE_TRAIL(T_STROBE), .PULSE_CYCLES(T_PULSE),
    .PERIOD_CYCLES(T_PERIOD)) dut (.clk(clk), .resetn(resetn), .format_sel(format_sel),
    .strobe_enable(strobe_enable), .cred_valid(cred_valid), .cred_ready(cred_ready),
    .cred_facility(cred_facility), .cred_user(cred_user), .data_line_out(d_out),
    .data_line_oe_n(d_oe_n), .clock_line_out(c_out), .clock_line_oe_n(c_oe_n),
    .card_present_strobe_out(s_out), .card_present_strobe_oe_n(s_oe_n), .busy(busy));

  // Pull-ups hold every released line high; an enabled driver shows its out level
  assign pulse_sel   = (format_sel == FMT_PULSE33);
  assign data_wire   = d_oe_n | d_out;
  assign clock_wire  = c_oe_n | c_out;
  assign strobe_wire = s_oe_n | s_out;
  cso_rx_model rx (.clk(clk), .resetn(resetn), .pulse_mode(pulse_sel),
    .data_wire(data_wire), .clock_wire(clock_wire), .strobe_wire(strobe_wire),
    .low_width(low_width), .period(period), .strobe_lead(strobe_lead),
    .strobe_trail(strobe_trail));

  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      fails++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, expv);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Character: nibble LSB first, then odd parity
  task automatic put_char(input logic [3:0] n);
    for (int i = 0; i < 4; i++) exp_bits.push_back(n[i]);
    exp_bits.push_back(~^n);
    lrc = lrc ^ n;
  endtask : put_char

  task automatic put_zeros(input int k);
    repeat (k) exp_bits.push_back(1'b0);
  endtask : put_zeros

  task automatic build_clocked(input fmt_t fmt, input logic [31:0] fac, input logic [31:0] uid);
    logic [3:0]  l;
    logic [31:0] k;
    k = 32'h1a210001;
    lrc = 4'h0;
    if (fmt != FMT_PLAIN) put_zeros(fmt == FMT_EXT ? 15 : 10);
    put_char(4'hb);
    if (fmt == FMT_EXT) begin
      for (int i = 7; i >= 0; i--) put_char(k[i*4 +: 4]);
      for (int i = 3; i >= 0; i--) put_char(fac[i*4 +: 4]);
      put_char(4'h0);
      put_char(4'h1);
      for (int i = 5; i >= 0; i--) put_char(uid[i*4 +: 4]);
    end else begin
      for (int i = 4; i >= 0; i--) put_char(fac[i*4 +: 4]);
      for (int i = 4; i >= 0; i--) put_char(uid[i*4 +: 4]);
    end
    put_char(4'hf);
    l = lrc;
    if (fmt != FMT_PLAIN) put_char(l);
    if (fmt == FMT_EXT) put_zeros(15);
  endtask : build_clocked

  task automatic build_pulse(input logic [15:0] fac, input logic [15:0] uid);
    for (int i = 15; i >= 0; i--) exp_bits.push_back(fac[i]);
    for (int i = 15; i >= 0; i--) exp_bits.push_back(uid[i]);
    exp_bits.push_back(~^{fac, uid});
  endtask : build_pulse

  // Bounded wait until the transmitter has been quiet for a while
  task automatic wait_idle();
    int quiet;
    int n;
    quiet = 0;
    n = 0;
    while (quiet < 8 && n < 40000) begin
      @(posedge clk);
      n++;
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    // A transmitter that never goes quiet counts as a mismatch
    if (quiet < 8) fails++;
  endtask : wait_idle

  task automatic send(input fmt_t fmt, input logic stb, input logic [31:0] fac,
                      input logic [31:0] uid);
    @(posedge clk);
    format_sel    <= fmt;
    strobe_enable <= stb;
    cred_facility <= fac;
    cred_user     <= uid;
    cred_valid    <= 1'b1;
    do @(posedge clk); while (cred_ready !== 1'b1);
    cred_valid <= 1'b0;
    wait_idle();
  endtask : send

  task automatic compare_bits();
    check(rx.bits.size(), exp_bits.size());
    for (int i = 0; i < exp_bits.size() && i < rx.bits.size(); i++)
      check(rx.bits[i], exp_bits[i]);
    rx.bits.delete();
    exp_bits.delete();
  endtask : compare_bits

  task automatic test_pulse();
    build_pulse(16'hc35a, 16'h8001);
    send(FMT_PULSE33, 1'b0, 32'h0000c35a, 32'h00008001);
    compare_bits();
    check(c_oe_n, 1'b1);
    $display("test_pulse done");
  endtask : test_pulse

  task automatic test_plain();
    build_clocked(FMT_PLAIN, 32'h00000563, 32'h00003551);
    send(FMT_PLAIN, 1'b1, 32'h00000563, 32'h00003551);
    compare_bits();
    check(low_width, 16'd20);
    check(period, 16'd80);
    check(strobe_lead, 16'd70);
    check(strobe_trail, 16'h6e);
    check({s_oe_n, d_oe_n, c_oe_n}, 3'h7);
    $display("test_plain done");
  endtask : test_plain

  task automatic test_zero();
    build_clocked(FMT_ZERO, 32'h00099999, 32'h00000000);
    send(FMT_ZERO, 1'b0, 32'h00099999, 32'h00000000);
    compare_bits();
    $display("test_zero done");
  endtask : test_zero

  task automatic test_ext();
    build_clocked(FMT_EXT, 32'h00009876, 32'h00123450);
    send(FMT_EXT, 1'b1, 32'h00009876, 32'h00123450);
    compare_bits();
    $display("test_ext done");
  endtask : test_ext

  // Back-to-back pushes until the queue refuses, then every message in order
  task automatic test_backlog();
    int n;
    n = 0;
    @(posedge clk);
    format_sel    <= FMT_PULSE33;
    strobe_enable <= 1'b0;
    cred_facility <= 32'h00000101;
    cred_user     <= 32'h0;
    cred_valid    <= 1'b1;
    while (n < 12) begin
      @(posedge clk);
      if (cred_ready !== 1'b1) break;
      n++;
      cred_user <= n;
    end
    cred_valid <= 1'b0;
    check(n, 9);
    for (int k = 0; k < n; k++) build_pulse(16'h0101, k[15:0]);
    wait_idle();
    compare_bits();
    $display("test_backlog done");
  endtask : test_backlog

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog sized well past the expected run of about 170 us
  initial begin
    #400000;
    fails++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    resetn        = 1'b0;
    format_sel    = FMT_PULSE33;
    strobe_enable = 1'b0;
    cred_valid    = 1'b0;
    cred_facility = 32'h0;
    cred_user     = 32'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    test_pulse();
    test_plain();
    test_zero();
    test_ext();
    test_backlog();
    close_out();
  end
endmodule : tb_credential_serial_output

`default_nettype wire
